// ===== rtl/scpmc_pkg.sv
package scpmc_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_MODE_CTRL = 8'h00;
  localparam logic [7:0] ADDR_IDLE_FLAGS = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;

  // mode control field positions
  localparam int CKS_HI = 7;
  localparam int CKS_LO = 5;
  localparam int SLOW_RDY_BIT = 3;
  localparam int FAST_RDY_BIT = 2;
  localparam int WAIT_EN_BIT = 1;
  localparam int HL_SEL_BIT = 0;

  // idle/flags field positions
  localparam int KEEP_ON_BIT = 7;
  localparam int RSVD_BIT = 3;
  localparam int LVR_BIT = 2;
  localparam int WRF_BIT = 0;

  // reset values of the writable mode control bits
  localparam logic [2:0] CKS_RESET = 3'h0;
  localparam logic WAIT_EN_RESET = 1'h1;
  localparam logic HL_SEL_RESET = 1'h1;

  // divider: shift 0 = undivided, 6 = divide by 64
  localparam logic [2:0] DIV_SHIFT_BASE = 3'h0;
  localparam logic [3:0] DIV_SHIFT_SUM = 4'h8;
  localparam logic [2:0] DIV_SHIFT_MAX = 3'h6;
  localparam logic [2:0] CKS_FIRST_FAST = 3'h2;
  localparam logic [5:0] DIV_ALL_ONES = 6'h3F;
  localparam logic [5:0] DIV16_MASK = 6'h0F;

  // slow oscillator settles after this many slow ticks
  localparam logic [1:0] SLOW_READY_TICKS = 2'h2;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // operating modes, gray coded along run -> wait -> stop
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'h0,
    MODE_SLOW = 3'h1,
    MODE_WAIT_ON = 3'h3,
    MODE_WAIT_OFF = 3'h2,
    MODE_STOP_WDT = 3'h6,
    MODE_STOP_DEEP = 3'h7
  } scpmc_mode_e;

  // clock and power enables handed to the rest of the chip
  typedef struct packed {
    logic cpuRun;
    logic fastOscEn;
    logic slowOscEn;
    logic timeBaseEn;
  } scpmc_power_s;

  // clock ticks handed to the rest of the chip
  typedef struct packed {
    logic sysClkTick;
    logic fastDiv16Tick;
    logic fastDiv64Tick;
  } scpmc_ticks_s;

endpackage

// ===== rtl/scpmc_top.sv
`timescale 1ns/10ps
// Operation
// - six modes: two running, four CPU-off
// - normal mode: fast clock divided 1..64
// - slow mode: slow clock, fast oscillator off
// - halt, wait low, watchdog off: deep stop
// - halt, wait low, watchdog on: stop, slow clock kept
// - halt, wait high, keep-on low: clocks-off wait
// - halt, wait and keep-on high: clocks-on wait
// - divider field picks slow or fast/64..fast/2
// - high/low select high gives undivided fast clock
// - moving to slow clock stops fast oscillator
// - fast/16 and fast/64 ticks stop too
// - slow ready low in deep stop, 2 ticks
// - fast ready cleared at reset, set when stable
// - wait enable picks wait or stop on halt
// - keep-on bit enables system clock in wait
// - low-voltage flag: hardware sets, software clears only
// - soft reset flag: hardware sets, software clears only
// - unimplemented bits read as zero
// - halt sets power-down, clears watchdog expiry
module scpmc_top
  import scpmc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // oscillator ticks and status
  input wire logic fastOscTick,
  input wire logic slowOscTick,
  input wire logic fastOscStable,
  // cpu, watchdog and reset events
  input wire logic haltReq,
  input wire logic wakeUp,
  input wire logic wdtEnabled,
  input wire logic lowVoltReset,
  input wire logic wdtSoftReset,
  // clock and power outputs
  output scpmc_power_s power,
  output scpmc_ticks_s ticks,
  output scpmc_mode_e mode,
  // status register side effects
  output logic powerDownSet,
  output logic expiryClear
);

  // software visible control bits
  logic [2:0] clkDivSel;
  logic waitEnable;
  logic hlClkSel;
  logic keepOnIdle;
  logic reservedBit;
  logic lowVoltFlag;
  logic softResetFlag;
  logic slowReady;
  logic fastReady;

  // clock path state
  logic activeSlow;
  logic [2:0] activeShift;
  logic [5:0] divCnt;
  logic [1:0] slowCnt;

  // bus state
  logic awHeld;
  logic wHeld;
  logic [7:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;

  // decoded requests and ticks
  logic wrEn;
  logic wrLow;
  logic reqSlow;
  logic [2:0] reqShift;
  logic fastTick;
  logic slowTick;
  logic boundary;
  logic [5:0] divMask;
  logic running;
  logic [31:0] readWord;
  logic readHit;

  // write fires once both halves are held and no response is out
  assign wrEn = awHeld && wHeld && !s_axi_bvalid;
  assign wrLow = wrEn && wStrb[0];

  // requested source and shift from the control bits
  always_comb begin
    reqSlow = !hlClkSel && (clkDivSel < CKS_FIRST_FAST);
    if (hlClkSel) begin
      reqShift = DIV_SHIFT_BASE;
    end else if (reqSlow) begin
      reqShift = DIV_SHIFT_BASE;
    end else begin
      reqShift = 3'(DIV_SHIFT_SUM - {1'b0, clkDivSel});
    end
  end

  // ticks only count while their oscillator is allowed to run
  assign fastTick = fastOscTick && power.fastOscEn;
  assign slowTick = slowOscTick && power.slowOscEn;
  // all ratios share this edge, so a change here never cuts a period
  assign boundary = fastTick && (divCnt == DIV_ALL_ONES);
  assign divMask = DIV_ALL_ONES >> (DIV_SHIFT_MAX - activeShift);
  assign running = (mode == MODE_NORMAL) || (mode == MODE_SLOW);

  // axi write address and data channels, either order
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 8'h00;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
      end else if (!awHeld && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_wready <= 1'b1;
      end else if (!wHeld && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (wrEn) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
      end
    end
  end

  // axi write response, error for any address but the two writable registers
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wrEn) begin
      s_axi_bvalid <= 1'b1;
      if (awAddr == ADDR_MODE_CTRL || awAddr == ADDR_IDLE_FLAGS) begin
        s_axi_bresp <= RESP_OKAY;
      end else begin
        s_axi_bresp <= RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read word assembly; unimplemented bits are zero
  always_comb begin
    readWord = 32'h0000_0000;
    readHit = 1'b1;
    unique case (s_axi_araddr)
      ADDR_MODE_CTRL: begin
        readWord[CKS_HI:CKS_LO] = clkDivSel;
        readWord[SLOW_RDY_BIT] = slowReady;
        readWord[FAST_RDY_BIT] = fastReady;
        readWord[WAIT_EN_BIT] = waitEnable;
        readWord[HL_SEL_BIT] = hlClkSel;
      end
      ADDR_IDLE_FLAGS: begin
        readWord[KEEP_ON_BIT] = keepOnIdle;
        readWord[RSVD_BIT] = reservedBit;
        readWord[LVR_BIT] = lowVoltFlag;
        readWord[WRF_BIT] = softResetFlag;
      end
      ADDR_STATUS: begin
        readWord[2:0] = mode;
      end
      default: begin
        readHit = 1'b0;
      end
    endcase
  end

  // axi read channel, answer one cycle after the address
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= readWord;
      s_axi_rresp <= readHit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // mode control register, writable fields only
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      clkDivSel <= CKS_RESET;
      waitEnable <= WAIT_EN_RESET;
      hlClkSel <= HL_SEL_RESET;
    end else if (wrLow && awAddr == ADDR_MODE_CTRL) begin
      clkDivSel <= wData[CKS_HI:CKS_LO];
      waitEnable <= wData[WAIT_EN_BIT];
      hlClkSel <= wData[HL_SEL_BIT];
    end
  end

  // idle keep-on and reserved storage
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      keepOnIdle <= 1'b0;
      reservedBit <= 1'b0;
    end else if (wrLow && awAddr == ADDR_IDLE_FLAGS) begin
      keepOnIdle <= wData[KEEP_ON_BIT];
      reservedBit <= wData[RSVD_BIT];
    end
  end

  // sticky reset-cause flags: writing one is ignored, set beats clear
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      lowVoltFlag <= 1'b0;
      softResetFlag <= 1'b0;
    end else begin
      if (lowVoltReset) begin
        lowVoltFlag <= 1'b1;
      end else if (wrLow && awAddr == ADDR_IDLE_FLAGS && !wData[LVR_BIT]) begin
        lowVoltFlag <= 1'b0;
      end
      if (wdtSoftReset) begin
        softResetFlag <= 1'b1;
      end else if (wrLow && awAddr == ADDR_IDLE_FLAGS && !wData[WRF_BIT]) begin
        softResetFlag <= 1'b0;
      end
    end
  end

  // operating mode sequencer
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      mode <= MODE_NORMAL;
    end else begin
      unique case (mode)
        MODE_NORMAL, MODE_SLOW: begin
          if (haltReq && waitEnable && keepOnIdle) begin
            mode <= MODE_WAIT_ON;
          end else if (haltReq && waitEnable) begin
            mode <= MODE_WAIT_OFF;
          end else if (haltReq && wdtEnabled) begin
            mode <= MODE_STOP_WDT;
          end else if (haltReq) begin
            mode <= MODE_STOP_DEEP;
          end else begin
            mode <= activeSlow ? MODE_SLOW : MODE_NORMAL;
          end
        end
        MODE_WAIT_ON, MODE_WAIT_OFF, MODE_STOP_WDT, MODE_STOP_DEEP: begin
          if (wakeUp) begin
            mode <= activeSlow ? MODE_SLOW : MODE_NORMAL;
          end
        end
        default: begin
          mode <= MODE_NORMAL;
        end
      endcase
    end
  end

  // halt side effects on the cpu status register
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      powerDownSet <= 1'b0;
      expiryClear <= 1'b0;
    end else begin
      powerDownSet <= haltReq && running;
      expiryClear <= haltReq && running;
    end
  end

  // source switch waits for a common edge; fast needs ready first
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      activeSlow <= 1'b0;
      activeShift <= DIV_SHIFT_BASE;
    end else if (boundary && (reqSlow || fastReady)) begin
      activeSlow <= reqSlow;
      activeShift <= reqShift;
    end
  end

  // fast divider chain
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      divCnt <= 6'h00;
    end else if (fastTick) begin
      divCnt <= divCnt + 6'h01;
    end
  end

  // oscillator enables per mode
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      power <= '{cpuRun: 1'b1, fastOscEn: 1'b1, slowOscEn: 1'b1,
                 timeBaseEn: 1'b1};
    end else begin
      power.cpuRun <= running;
      // fast stays up while a switch away from it is still pending
      power.fastOscEn <= (running && !(activeSlow && reqSlow))
                         || (mode == MODE_WAIT_ON && !activeSlow);
      power.slowOscEn <= (mode != MODE_STOP_DEEP)
                         && !(mode == MODE_STOP_WDT && !wdtEnabled);
      power.timeBaseEn <= (mode != MODE_STOP_DEEP)
                          && (mode != MODE_STOP_WDT);
    end
  end

  // system and peripheral ticks
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ticks <= '0;
    end else begin
      if (running || mode == MODE_WAIT_ON) begin
        if (activeSlow) begin
          ticks.sysClkTick <= slowTick;
        end else begin
          ticks.sysClkTick <= fastTick
                              && ((divCnt & divMask) == divMask);
        end
      end else begin
        ticks.sysClkTick <= 1'b0;
      end
      // gated with the oscillator, so these die with it
      ticks.fastDiv16Tick <= fastTick
                             && ((divCnt & DIV16_MASK) == DIV16_MASK);
      ticks.fastDiv64Tick <= boundary;
    end
  end

  // oscillator ready flags
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      slowCnt <= 2'h0;
      slowReady <= 1'b0;
      fastReady <= 1'b0;
    end else begin
      if (!power.slowOscEn) begin
        slowCnt <= 2'h0;
      end else if (slowTick && slowCnt != SLOW_READY_TICKS) begin
        slowCnt <= slowCnt + 2'h1;
      end
      slowReady <= power.slowOscEn && (slowCnt == SLOW_READY_TICKS);
      fastReady <= power.fastOscEn && fastOscStable;
    end
  end

endmodule

// ===== verif/scpmc_properties.sv
`timescale 1ns/10ps
module scpmc_properties
  import scpmc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // events
  input wire logic haltReq,
  input wire logic wdtEnabled,
  // watched outputs
  input wire scpmc_power_s power,
  input wire scpmc_ticks_s ticks,
  input wire scpmc_mode_e mode,
  input wire logic powerDownSet,
  input wire logic expiryClear
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // halt only counts while the cpu runs
  sequence s_halt;
    haltReq && (mode == MODE_NORMAL || mode == MODE_SLOW);
  endsequence
  // slow mode judged as it is entered; a later request for the fast
  // clock restarts the oscillator while mode still reads slow
  sequence s_slowEntry;
    (mode != MODE_SLOW) ##1 (mode == MODE_SLOW);
  endsequence
  // power lags mode by one edge, so modes are held before judging
  sequence s_deepHeld;
    (mode == MODE_STOP_DEEP)[*2];
  endsequence

  chk_halt_flags: assert property (
    s_halt |=> powerDownSet && expiryClear)
    else $error("halt flags missing");
  chk_halt_leaves: assert property (
    s_halt |=> mode != MODE_NORMAL && mode != MODE_SLOW)
    else $error("halt did not leave run");
  chk_halt_refused: assert property (
    haltReq && mode[1] |=> !powerDownSet)
    else $error("halt taken while halted");
  chk_run_cpu: assert property (
    (mode == MODE_NORMAL || mode == MODE_SLOW)[*2] |-> power.cpuRun)
    else $error("cpu off in run mode");
  chk_slow_fastoff: assert property (
    s_slowEntry |-> !power.fastOscEn)
    else $error("fast clock alive in slow mode");
  chk_ticks_die: assert property (
    !power.fastOscEn |=> !ticks.fastDiv16Tick && !ticks.fastDiv64Tick)
    else $error("fast ticks alive with oscillator off");
  chk_deep_stop: assert property (
    s_deepHeld |-> power == 4'h0)
    else $error("deep stop power wrong");
  chk_stop_wdt: assert property (
    (mode == MODE_STOP_WDT && wdtEnabled)[*2] |-> power == 4'h2)
    else $error("watchdog stop power wrong");
  chk_wait_off: assert property (
    (mode == MODE_WAIT_OFF)[*3] |-> power == 4'h3 && !ticks.sysClkTick)
    else $error("clocks-off wait wrong");
  chk_wait_on: assert property (
    (mode == MODE_WAIT_ON)[*2]
      |-> !power.cpuRun && power.slowOscEn && power.timeBaseEn)
    else $error("clocks-on wait wrong");
endmodule

bind scpmc_top scpmc_properties u_props (.sys_clk(sys_clk), .resetn(resetn),
  .haltReq(haltReq), .wdtEnabled(wdtEnabled), .power(power), .ticks(ticks),
  .mode(mode), .powerDownSet(powerDownSet), .expiryClear(expiryClear));

// ===== verif/system_clock_power_mode_control_tb.sv
`timescale 1ns/10ps
module system_clock_power_mode_control_tb
  import scpmc_pkg::*;
;
  logic sys_clk = 0, resetn = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rnd = 0;
  logic [3:0] wstrb = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic slowTick = 0, haltReq = 0, wakeUp = 0, wdtEn = 0, lvr = 0, swr = 0;
  wire logic awready, wready, bvalid, arready, rvalid, pdSet, toClr;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  scpmc_power_s power;
  scpmc_ticks_s ticks;
  scpmc_mode_e mode;
  logic [33:0] expR[$];
  logic [1:0] expB[$];
  logic [33:0] expNow;
  logic [3:0] pw[4] = '{4'h3, 4'h7, 4'h2, 4'h0};
  logic [2:0] md[4] = '{3'h2, 3'h3, 3'h6, 3'h7};
  int fails = 0, nChecks = 0, seed = 76, slowCnt = 0;
  int nSys, n16, n64, expSys;

  always #2 sys_clk = ~sys_clk;
  // slow oscillator modelled as one tick every eight cycles
  always @(posedge sys_clk) begin
    slowCnt <= slowCnt + 1;
    slowTick <= (slowCnt % 8 == 7);
  end

  // fast oscillator ticks every cycle and is always stable
  scpmc_top dut (.sys_clk(sys_clk), .resetn(resetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .fastOscTick(1'b1),
    .slowOscTick(slowTick), .fastOscStable(1'b1), .haltReq(haltReq),
    .wakeUp(wakeUp), .wdtEnabled(wdtEn), .lowVoltReset(lvr),
    .wdtSoftReset(swr), .power(power), .ticks(ticks), .mode(mode),
    .powerDownSet(pdSet), .expiryClear(toClr));

  task automatic chk(input string nm, input logic [31:0] e, g);
    nChecks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", nChecks, fails);
    if (fails == 0 && nChecks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [1:0] r);
    expB.push_back(r);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // no cycle count assumed; only the watchdog ends a hung wait
    do begin
      @(posedge sys_clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r);
    expR.push_back({r, d});
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  // responses are matched against the oldest note as they appear
  always @(posedge sys_clk) begin
    if (bvalid === 1'b1 && bready) begin
      chk("bresp", {30'h0, expB.pop_front()}, {30'h0, bresp});
    end
    if (rvalid === 1'b1 && rready) begin
      expNow = expR.pop_front();
      chk("rdata", expNow[31:0], rdata);
      chk("rresp", {30'h0, expNow[33:32]}, {30'h0, rresp});
    end
  end

  // bound well above the expected run of about 3700 cycles
  initial begin
    #80000;
    fails++;
    complete_run;
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (300) @(posedge sys_clk);
    axr(ADDR_MODE_CTRL, 32'h0F, RESP_OKAY);
    axr(ADDR_IDLE_FLAGS, 32'h00, RESP_OKAY);
    axr(8'h0C, 32'h00, RESP_SLVERR);
    axw(8'h0C, 32'hFF, 4'hF, RESP_SLVERR);
    axw(ADDR_MODE_CTRL, 32'h00, 4'h0, RESP_OKAY);
    axr(ADDR_MODE_CTRL, 32'h0F, RESP_OKAY);
    $display("test registers done");
    rnd = $random(seed);
    axw(ADDR_IDLE_FLAGS, rnd, 4'hF, RESP_OKAY);
    axr(ADDR_IDLE_FLAGS, rnd & 32'h88, RESP_OKAY);
    @(posedge sys_clk);
    lvr <= 1'b1;
    swr <= 1'b1;
    @(posedge sys_clk);
    lvr <= 1'b0;
    swr <= 1'b0;
    axr(ADDR_IDLE_FLAGS, (rnd & 32'h88) | 32'h05, RESP_OKAY);
    axw(ADDR_IDLE_FLAGS, 32'h00, 4'hF, RESP_OKAY);
    axr(ADDR_IDLE_FLAGS, 32'h00, RESP_OKAY);
    $display("test flags done");
    // every divider code, then the undivided fast clock
    for (int c = 0; c < 9; c++) begin
      axw(ADDR_MODE_CTRL, (c == 8) ? 32'h03 : {24'h0, c[2:0], 5'h02},
          4'hF, RESP_OKAY);
      repeat (200) @(posedge sys_clk);
      nSys = 0;
      n16 = 0;
      n64 = 0;
      repeat (128) begin
        @(posedge sys_clk);
        if (ticks.sysClkTick === 1'b1) nSys++;
        if (ticks.fastDiv16Tick === 1'b1) n16++;
        if (ticks.fastDiv64Tick === 1'b1) n64++;
      end
      expSys = (c == 8) ? 128 : (c < 2) ? 16 : 128 >> (8 - c);
      chk("sysTicks", expSys, nSys);
      chk("div16Ticks", (c < 2) ? 0 : 8, n16);
      chk("div64Ticks", (c < 2) ? 0 : 2, n64);
      chk("fastOscEn", {31'h0, c >= 2}, {31'h0, power.fastOscEn});
      axr(ADDR_STATUS, (c < 2) ? 32'h1 : 32'h0, RESP_OKAY);
      // fast ready read back after the ticks are counted, set only for the fast codes
      axr(ADDR_MODE_CTRL, (c == 8) ? 32'h0F
          : {24'h0, c[2:0], 2'h1, c >= 2, 2'h2}, RESP_OKAY);
    end
    $display("test clocks done");
    for (int i = 0; i < 4; i++) begin
      axw(ADDR_MODE_CTRL, {30'h0, i < 2, 1'b1}, 4'hF, RESP_OKAY);
      axw(ADDR_IDLE_FLAGS, {24'h0, i == 1, 7'h0}, 4'hF, RESP_OKAY);
      rnd = $random(seed);
      @(posedge sys_clk);
      wdtEn <= (i < 2) ? rnd[0] : (i == 2);
      haltReq <= 1'b1;
      @(posedge sys_clk);
      haltReq <= 1'b0;
      @(posedge sys_clk);
      chk("powerDownSet", 32'h1, {31'h0, pdSet});
      chk("expiryClear", 32'h1, {31'h0, toClr});
      haltReq <= 1'b1;
      @(posedge sys_clk);
      haltReq <= 1'b0;
      @(posedge sys_clk);
      chk("refusedHalt", 32'h0, {31'h0, pdSet});
      repeat (4) @(posedge sys_clk);
      chk("mode", {29'h0, md[i]}, {29'h0, mode});
      chk("power", {28'h0, pw[i]}, {28'h0, power});
      if (i == 3) axr(ADDR_MODE_CTRL, 32'h01, RESP_OKAY);
      @(posedge sys_clk);
      wakeUp <= 1'b1;
      @(posedge sys_clk);
      wakeUp <= 1'b0;
      repeat (40) @(posedge sys_clk);
      axr(ADDR_STATUS, 32'h0, RESP_OKAY);
      axr(ADDR_MODE_CTRL, {28'h0, 2'h3, i < 2, 1'b1}, RESP_OKAY);
    end
    $display("test power modes done");
    complete_run;
  end
endmodule
